// ### acq_trigger_ctrl.sv
// Purpose: Capture arming, disarming and arming trigger gating
// Assumes: Frame triggers and frame done come from clk_sys logic
// Notes: Registers on a plain port, read data one cycle after strobe
//
// Overview of operation
// - No frame is taken until the host issues the capture arm command.
// - Disarm with no frame in progress ends capture at once.
// - Disarm during a frame lets it finish, then no new frame starts.
// - One-shot style takes one frame then disarms itself.
// - Continuous style takes one frame per trigger while waiting, until disarm.
// - One-shot frames never overlap; each runs a full cycle alone.
// - Gate off: arming trigger is made internally.
// - Gate on: start waiting for arming trigger, discard frame triggers.
// - Arming trigger moves to waiting for frame trigger.
// - Gate on, continuous style: after frames_per_arm frames, go back to waiting for arming.
// - frames_per_arm takes 1 to 255; reset sets it to 1.
// - Return to arming wait happens only with the gate on.
// - Arming origin is host pulse, input one or gpio third input.
// - Each host pulse command gives one arming trigger.
// - Gpio third input counts only while configured as input.
// - Polarity select picks rising or falling edge of the line.
// - Frame triggers outside waiting for a frame are ignored.
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ns
module acq_trigger_ctrl #(
   parameter int FPA_W = acq_pkg::FPA_W
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [acq_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [acq_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [acq_pkg::DATA_W-1:0] reg_rdata,
   input wire logic input_one,
   input wire logic gpio_third_input,
   input wire logic frame_trig,
   input wire logic frame_done,
   output logic expose_start,
   output logic capture_enabled,
   output logic frame_wait,
   output logic arm_wait
);
   if (FPA_W < 8 || FPA_W > 16) begin : g_bad
      $error("FPA_W must be 8 to 16");
   end

   acq_pkg::acq_state_t state_r;
   acq_pkg::acq_state_t state_nxt;
   logic [acq_pkg::CTRL_W-1:0] ctrl_r;
   logic [7:0] fpa_r;
   logic [FPA_W-1:0] cnt_r;
   logic stop_pend_r;
   logic input_one_rise;
   logic input_one_fall;
   logic gpio_third_input_rise;
   logic gpio_third_input_fall;
   logic wr_ctrl;
   logic wr_fpa;
   logic wr_cmd;
   logic arm_cmd;
   logic disarm_cmd;
   logic host_pulse;
   logic arm_trig;
   logic run_style;
   logic gate_on;
   logic polarity;
   acq_pkg::origin_t origin;
   logic gpio_third_input_is_input;
   logic count_reached;

   function automatic logic hit(input logic [acq_pkg::ADDR_W-1:0] a,
                                input logic [acq_pkg::ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   function automatic logic pick_edge(input logic pol, input logic rise,
                                      input logic fall);
      pick_edge = (pol == acq_pkg::POL_UPWARD) ? rise : fall;
   endfunction : pick_edge

   line_edge_sync u_line_one (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .line_in(input_one),
      .rise_r(input_one_rise),
      .fall_r(input_one_fall)
   );

   line_edge_sync u_line_three (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .line_in(gpio_third_input),
      .rise_r(gpio_third_input_rise),
      .fall_r(gpio_third_input_fall)
   );

   assign wr_ctrl = reg_wr && hit(reg_addr, acq_pkg::OFS_CTRL);
   assign wr_fpa = reg_wr && hit(reg_addr, acq_pkg::OFS_FPA);
   assign wr_cmd = reg_wr && hit(reg_addr, acq_pkg::OFS_CMD);
   assign arm_cmd = wr_cmd && reg_wdata[acq_pkg::CMD_ARM];
   assign disarm_cmd = wr_cmd && reg_wdata[acq_pkg::CMD_DISARM];
   assign host_pulse = wr_cmd && reg_wdata[acq_pkg::CMD_HOST_PULSE];

   assign run_style = ctrl_r[acq_pkg::CTRL_RUN_STYLE];
   assign gate_on = ctrl_r[acq_pkg::CTRL_GATE];
   assign polarity = ctrl_r[acq_pkg::CTRL_POLARITY];
   assign origin = acq_pkg::origin_t'(ctrl_r[acq_pkg::CTRL_ORIGIN_LO +: 2]);
   assign gpio_third_input_is_input = ctrl_r[acq_pkg::CTRL_GPIO_THIRD_INPUT_IN];

   // Arming trigger selection
   always_comb begin
      case (origin)
         acq_pkg::ORIGIN_HOST: arm_trig = host_pulse;
         acq_pkg::ORIGIN_INPUT_ONE:
            arm_trig = pick_edge(polarity, input_one_rise, input_one_fall);
         acq_pkg::ORIGIN_GPIO_THIRD:
            arm_trig = gpio_third_input_is_input &&
                       pick_edge(polarity, gpio_third_input_rise, gpio_third_input_fall);
         default: arm_trig = 1'b0;
      endcase
   end

   // Wider counter compares against the 8-bit setting
   assign count_reached = (cnt_r >= FPA_W'(fpa_r));

   // Configuration; run style and gate can be rewritten in any state, capturing included
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= acq_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_r <= reg_wdata[acq_pkg::CTRL_W-1:0];
      end
   end

   // Zero is out of range and is ignored, keeping the old count
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fpa_r <= acq_pkg::FPA_RESET;
      end else if (wr_fpa && reg_wdata[7:0] >= acq_pkg::FPA_MIN) begin
         fpa_r <= reg_wdata[7:0];
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         acq_pkg::ST_DISARMED: begin
            if (arm_cmd && !disarm_cmd) begin
               state_nxt = gate_on ? acq_pkg::ST_WAIT_ARM
                                   : acq_pkg::ST_WAIT_FRAME;
            end
         end
         acq_pkg::ST_WAIT_ARM: begin
            if (disarm_cmd) begin
               state_nxt = acq_pkg::ST_DISARMED;
            end else if (arm_trig) begin
               state_nxt = acq_pkg::ST_WAIT_FRAME;
            end
         end
         acq_pkg::ST_WAIT_FRAME: begin
            if (disarm_cmd) begin
               state_nxt = acq_pkg::ST_DISARMED;
            end else if (frame_trig) begin
               state_nxt = acq_pkg::ST_FRAME_BUSY;
            end
         end
         acq_pkg::ST_FRAME_BUSY: begin
            // Busy frame ignores triggers, so frames never overlap
            if (frame_done) begin
               if (stop_pend_r || disarm_cmd) begin
                  state_nxt = acq_pkg::ST_DISARMED;
               end else if (run_style == acq_pkg::RUN_ONE_SHOT) begin
                  state_nxt = acq_pkg::ST_DISARMED;
               end else if (gate_on && count_reached) begin
                  state_nxt = acq_pkg::ST_WAIT_ARM;
               end else begin
                  state_nxt = acq_pkg::ST_WAIT_FRAME;
               end
            end
         end
         default: state_nxt = acq_pkg::ST_DISARMED;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r <= acq_pkg::ST_DISARMED;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Disarm during a frame is remembered until the frame ends
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         stop_pend_r <= 1'b0;
      end else if (state_nxt != acq_pkg::ST_FRAME_BUSY) begin
         stop_pend_r <= 1'b0;
      end else if (disarm_cmd) begin
         stop_pend_r <= 1'b1;
      end
   end

   // Only accepted triggers count
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= '0;
      end else if (state_r == acq_pkg::ST_DISARMED ||
                   (state_r == acq_pkg::ST_WAIT_ARM && arm_trig)) begin
         cnt_r <= '0;
      end else if (state_r == acq_pkg::ST_WAIT_FRAME &&
                   state_nxt == acq_pkg::ST_FRAME_BUSY &&
                   cnt_r != '1) begin
         cnt_r <= cnt_r + FPA_W'(1);
      end
   end

   // Status outputs, all from flops
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         expose_start <= 1'b0;
         capture_enabled <= 1'b0;
         frame_wait <= 1'b0;
         arm_wait <= 1'b0;
      end else begin
         expose_start <= (state_r == acq_pkg::ST_WAIT_FRAME) &&
                         (state_nxt == acq_pkg::ST_FRAME_BUSY);
         capture_enabled <= (state_nxt != acq_pkg::ST_DISARMED);
         frame_wait <= (state_nxt == acq_pkg::ST_WAIT_FRAME);
         arm_wait <= (state_nxt == acq_pkg::ST_WAIT_ARM);
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_rd) begin
            case (reg_addr)
               acq_pkg::OFS_CTRL:
                  reg_rdata[acq_pkg::CTRL_W-1:0] <= ctrl_r;
               acq_pkg::OFS_FPA: reg_rdata[7:0] <= fpa_r;
               acq_pkg::OFS_STATUS: begin
                  reg_rdata[acq_pkg::STAT_STATE_LO +: 3] <= state_r;
                  reg_rdata[acq_pkg::STAT_STOP_PEND] <= stop_pend_r;
                  reg_rdata[acq_pkg::STAT_CNT_LO +: FPA_W] <= cnt_r;
               end
               default: reg_rdata <= '0;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_disarm_busy;
      state_r == acq_pkg::ST_FRAME_BUSY && disarm_cmd && !frame_done;
   endsequence
   sequence s_frame_held;
      state_r == acq_pkg::ST_FRAME_BUSY && stop_pend_r;
   endsequence

   property p_no_arm_no_capture;
      state_r == acq_pkg::ST_DISARMED && !arm_cmd |=>
         state_r == acq_pkg::ST_DISARMED ##1 !expose_start;
   endproperty
   a_no_arm_no_capture: assert property (p_no_arm_no_capture)
      else $error("capture left disarmed without arm command");

   property p_disarm_idle;
      (state_r == acq_pkg::ST_WAIT_ARM || state_r == acq_pkg::ST_WAIT_FRAME)
         && disarm_cmd |=> state_r == acq_pkg::ST_DISARMED && !capture_enabled;
   endproperty
   a_disarm_idle: assert property (p_disarm_idle)
      else $error("disarm while idle did not end capture");

   property p_disarm_busy;
      s_disarm_busy |=> s_frame_held;
   endproperty
   a_disarm_busy: assert property (p_disarm_busy)
      else $error("frame not kept to completion after disarm");

   property p_pending_ends;
      (s_frame_held and frame_done) |=> state_r == acq_pkg::ST_DISARMED;
   endproperty
   a_pending_ends: assert property (p_pending_ends)
      else $error("capture continued after pending disarm");

   property p_one_shot;
      state_r == acq_pkg::ST_FRAME_BUSY && frame_done &&
         run_style == acq_pkg::RUN_ONE_SHOT |=>
         state_r == acq_pkg::ST_DISARMED && !capture_enabled;
   endproperty
   a_one_shot: assert property (p_one_shot)
      else $error("one-shot did not disarm after its frame");

   property p_trigger_exposes;
      state_r == acq_pkg::ST_WAIT_FRAME && frame_trig && !disarm_cmd |=>
         state_r == acq_pkg::ST_FRAME_BUSY && expose_start;
   endproperty
   a_trigger_exposes: assert property (p_trigger_exposes)
      else $error("frame trigger while waiting gave no exposure");

   property p_arm_wait_discard;
      state_r == acq_pkg::ST_WAIT_ARM && frame_trig && !arm_trig |=>
         ##1 !expose_start;
   endproperty
   a_arm_wait_discard: assert property (p_arm_wait_discard)
      else $error("frame trigger accepted while waiting for arming");

   property p_arm_trig_moves;
      state_r == acq_pkg::ST_WAIT_ARM && arm_trig && !disarm_cmd |=>
         state_r == acq_pkg::ST_WAIT_FRAME && cnt_r == '0;
   endproperty
   a_arm_trig_moves: assert property (p_arm_trig_moves)
      else $error("arming trigger did not open frame wait");

   property p_count_return;
      state_r == acq_pkg::ST_FRAME_BUSY && frame_done && gate_on &&
         run_style == acq_pkg::RUN_CONTINUOUS && !stop_pend_r &&
         !disarm_cmd && cnt_r == FPA_W'(fpa_r) |=>
         state_r == acq_pkg::ST_WAIT_ARM;
   endproperty
   a_count_return: assert property (p_count_return)
      else $error("frame count reached without return to arming wait");

   property p_ignored_trig;
      state_r != acq_pkg::ST_WAIT_FRAME |=> !expose_start;
   endproperty
   a_ignored_trig: assert property (p_ignored_trig)
      else $error("exposure started outside frame wait");
endmodule : acq_trigger_ctrl

// ### acq_pkg.sv
// Purpose: Shared constants for the capture arming and gating logic
// Assumes: 32-bit register port, byte offsets
// Notes: Field positions refer to the control, command and status registers
package acq_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int FPA_W = 8;
   // Register offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_FPA = 4'h4;
   localparam logic [3:0] OFS_CMD = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hC;
   // Control fields
   localparam int CTRL_RUN_STYLE = 0;
   localparam int CTRL_GATE = 1;
   localparam int CTRL_ORIGIN_LO = 2;
   localparam int CTRL_POLARITY = 4;
   localparam int CTRL_GPIO_THIRD_INPUT_IN = 5;
   localparam int CTRL_W = 6;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   // Command fields, write-only pulses
   localparam int CMD_ARM = 0;
   localparam int CMD_DISARM = 1;
   localparam int CMD_HOST_PULSE = 2;
   // Frames per arm limits and reset value
   localparam logic [7:0] FPA_MIN = 8'h01;
   localparam logic [7:0] FPA_MAX = 8'hFF;
   localparam logic [7:0] FPA_RESET = 8'h01;
   // Status fields
   localparam int STAT_STATE_LO = 0;
   localparam int STAT_STOP_PEND = 3;
   localparam int STAT_CNT_LO = 8;
   // Run style and polarity encodings
   localparam logic RUN_ONE_SHOT = 1'b0;
   localparam logic RUN_CONTINUOUS = 1'b1;
   localparam logic POL_UPWARD = 1'b0;
   localparam logic POL_DOWNWARD = 1'b1;
   typedef enum logic [1:0] {
      ORIGIN_HOST = 2'b00,
      ORIGIN_INPUT_ONE = 2'b01,
      ORIGIN_GPIO_THIRD = 2'b10
   } origin_t;
   typedef enum logic [2:0] {
      ST_DISARMED = 3'b000,
      ST_WAIT_ARM = 3'b001,
      ST_WAIT_FRAME = 3'b010,
      ST_FRAME_BUSY = 3'b011
   } acq_state_t;
endpackage : acq_pkg

// ### line_edge_sync.sv
// Purpose: Synchronise an external line and report its edges
// Assumes: Line is asynchronous to clk_sys
// Notes: A level counts once stages two and three agree
`timescale 1ns/1ns
module line_edge_sync (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic line_in,
   output logic rise_r,
   output logic fall_r
);
   logic sync1_r;
   logic sync2_r;
   logic sync3_r;
   logic level_r;

   // Stage one feeds stage two only
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end else begin
         sync1_r <= line_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Level starts low, so a line high at reset gives one rise
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         level_r <= 1'b0;
         rise_r <= 1'b0;
         fall_r <= 1'b0;
      end else begin
         rise_r <= 1'b0;
         fall_r <= 1'b0;
         if (sync2_r == sync3_r && sync2_r != level_r) begin
            level_r <= sync2_r;
            rise_r <= sync2_r;
            fall_r <= !sync2_r;
         end
      end
   end
endmodule : line_edge_sync

// ### frame_engine_model.sv
// Purpose: Frame engine model that ends each exposure
// Assumes: expose_start is a one-cycle pulse
// Notes: Fixed frame length keeps the disarm-in-frame window known
`timescale 1ns/1ns
module frame_engine_model #(
   parameter int FRAME_LEN = 10
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic expose_start,
   output logic frame_done
);
   int left_r;
   // One done pulse per exposure, never early
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         left_r <= 0;
         frame_done <= 1'b0;
      end else begin
         frame_done <= (left_r == 1);
         if (expose_start) begin
            left_r <= FRAME_LEN;
         end else if (left_r > 0) begin
            left_r <= left_r - 1;
         end
      end
   end
endmodule : frame_engine_model

// ### acq_trigger_ctrl_tb.sv
// Purpose: Self-checking bench for the capture arming logic
// Assumes: Frame engine model answers each exposure
// Notes: Gate only changes while disarmed, continuous when gate on
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
   bad_count++; $display("Error %s exp %0h got %0h", nm, exp, got); end end
module acq_trigger_ctrl_tb;
   localparam logic [31:0] CONT = 32'h1 << acq_pkg::CTRL_RUN_STYLE;
   localparam logic [31:0] GATE = 32'h1 << acq_pkg::CTRL_GATE;
   localparam logic [31:0] ORG1 = 32'h1 << acq_pkg::CTRL_ORIGIN_LO;
   localparam logic [31:0] ORG3 = 32'h2 << acq_pkg::CTRL_ORIGIN_LO;
   localparam logic [31:0] FALL = 32'h1 << acq_pkg::CTRL_POLARITY;
   localparam logic [31:0] L3IN = 32'h1 << acq_pkg::CTRL_GPIO_THIRD_INPUT_IN;
   localparam logic [31:0] ARM = 32'h1 << acq_pkg::CMD_ARM;
   localparam logic [31:0] DIS = 32'h1 << acq_pkg::CMD_DISARM;
   localparam logic [31:0] PULSE = 32'h1 << acq_pkg::CMD_HOST_PULSE;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [acq_pkg::ADDR_W-1:0] reg_addr = '0;
   logic [acq_pkg::DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [acq_pkg::DATA_W-1:0] reg_rdata;
   logic input_one = 1'b0;
   logic gpio_third_input = 1'b0;
   logic frame_trig = 1'b0;
   logic frame_done;
   logic expose_start;
   logic capture_enabled;
   logic frame_wait;
   logic arm_wait;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int expo = 0;
   // Line cases: origin bits, which line, start level, accepted
   logic [31:0] l_ctrl [8] = '{ORG1, ORG1 | FALL, ORG1 | FALL, ORG1,
      ORG3, ORG3 | L3IN, ORG3 | L3IN | FALL, ORG1 | ORG3};
   logic [7:0] l_w = 8'h78;
   logic [7:0] l_v = 8'h42;
   logic [7:0] l_ok = 8'h63;
   always #5 clk_sys = ~clk_sys;
   acq_trigger_ctrl dut_u (.clk_sys(clk_sys), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_one(input_one),
      .gpio_third_input(gpio_third_input), .frame_trig(frame_trig),
      .frame_done(frame_done), .expose_start(expose_start),
      .capture_enabled(capture_enabled), .frame_wait(frame_wait),
      .arm_wait(arm_wait));
   frame_engine_model eng_u (.clk_sys(clk_sys), .resetn(resetn),
      .expose_start(expose_start), .frame_done(frame_done));
   task automatic final_report;
      if (bad_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   // Ceiling well above the few hundred cycles the tests need
   always @(posedge clk_sys) begin
      cyc++;
      if (expose_start === 1'b1) expo++;
      if (cyc == 20000) begin
         bad_count++;
         final_report();
      end
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      `CHK("rdata", e, d)
      // Read data must fall back to zero after its one cycle
      @(posedge clk_sys);
      #1 `CHK("rdata_idle", 32'h0, reg_rdata)
   endtask : chk_rd
   // Status field and the three level outputs must agree
   task automatic st(input logic [2:0] s);
      logic [31:0] d;
      rd(acq_pkg::OFS_STATUS, d);
      `CHK("state", s, d[2:0])
      `CHK("capture_enabled", s != 3'h0, capture_enabled)
      `CHK("frame_wait", s == 3'h2, frame_wait)
      `CHK("arm_wait", s == 3'h1, arm_wait)
   endtask : st
   task automatic trig;
      @(posedge clk_sys);
      frame_trig <= 1'b1;
      @(posedge clk_sys);
      frame_trig <= 1'b0;
   endtask : trig
   // Longer than one frame of the engine model plus sync delay
   task automatic settle;
      repeat (16) @(posedge clk_sys);
   endtask : settle
   task automatic chk_expo(input int e);
      `CHK("exposures", e, expo)
   endtask : chk_expo
   task automatic line(input logic w, input logic v);
      @(posedge clk_sys);
      if (w) gpio_third_input <= v;
      else input_one <= v;
      repeat (8) @(posedge clk_sys);
   endtask : line
   initial begin
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      chk_rd(acq_pkg::OFS_CTRL, 32'(acq_pkg::CTRL_RESET));
      chk_rd(acq_pkg::OFS_FPA, 32'(acq_pkg::FPA_RESET));
      chk_rd(acq_pkg::OFS_CMD, 32'h0);
      wr(4'h2, 32'hFFFFFFFF);
      chk_rd(4'h2, 32'h0);
      chk_rd(acq_pkg::OFS_CTRL, 32'h0);
      // Arm and disarm in one write: disarm wins
      wr(acq_pkg::OFS_CMD, ARM | DIS);
      trig();
      settle();
      chk_expo(0);
      st(3'h0);
      wr(acq_pkg::OFS_CMD, ARM);
      st(3'h2);
      trig();
      st(3'h3);
      trig();
      settle();
      chk_expo(1);
      st(3'h0);
      trig();
      settle();
      chk_expo(1);
      wr(acq_pkg::OFS_CTRL, CONT);
      wr(acq_pkg::OFS_CMD, ARM);
      trig();
      settle();
      st(3'h2);
      trig();
      settle();
      chk_expo(3);
      wr(acq_pkg::OFS_CMD, DIS);
      st(3'h0);
      wr(acq_pkg::OFS_CMD, ARM);
      trig();
      wr(acq_pkg::OFS_CMD, DIS);
      st(3'h3);
      chk_rd(acq_pkg::OFS_STATUS, 32'h10B);
      settle();
      st(3'h0);
      trig();
      settle();
      chk_expo(4);
      wr(acq_pkg::OFS_FPA, 32'h0);
      chk_rd(acq_pkg::OFS_FPA, 32'h1);
      wr(acq_pkg::OFS_FPA, 32'hFF);
      chk_rd(acq_pkg::OFS_FPA, 32'hFF);
      wr(acq_pkg::OFS_FPA, 32'h2);
      wr(acq_pkg::OFS_CTRL, CONT | GATE);
      wr(acq_pkg::OFS_CMD, ARM);
      st(3'h1);
      trig();
      settle();
      chk_expo(4);
      chk_rd(acq_pkg::OFS_STATUS, 32'h1);
      wr(acq_pkg::OFS_CMD, PULSE);
      st(3'h2);
      trig();
      settle();
      chk_rd(acq_pkg::OFS_STATUS, 32'h102);
      trig();
      settle();
      st(3'h1);
      chk_expo(6);
      wr(acq_pkg::OFS_CMD, PULSE);
      chk_rd(acq_pkg::OFS_STATUS, 32'h2);
      wr(acq_pkg::OFS_CMD, DIS);
      for (int i = 0; i < 8; i++) begin
         line(l_w[i], l_v[i]);
         wr(acq_pkg::OFS_CTRL, CONT | GATE | l_ctrl[i]);
         wr(acq_pkg::OFS_CMD, ARM);
         st(3'h1);
         line(l_w[i], !l_v[i]);
         st(l_ok[i] ? 3'h2 : 3'h1);
         wr(acq_pkg::OFS_CMD, DIS);
      end
      final_report();
   end
endmodule : acq_trigger_ctrl_tb
